// *** hw/pac_pkg.sv ***
// Functional notes
// R1: a new sample is taken at every rising sample clock edge.
// R2: each result appears five clock cycles after its sample, one per cycle.
// R3: shutdown low, enable low: convert and drive data and overflow outputs.
// R4: shutdown low, enable high: keep converting, outputs high impedance.
// R5: shutdown high, enable low: nap, outputs high impedance.
// R6: both high: sleep, stop converting, outputs high impedance.
// R7: four-level format pin picks output format and clock stabilizer.
// R8: overflow flag high for out-of-range results, aligned with the word.
// R9: ten-bit parallel word, highest-numbered bit is the most significant.
// R10: two's complement equals offset binary with the top bit inverted.
// R11: capture logic discards first five words after leaving nap or sleep; pac_cap discards none and passes every word through while oe is high.
`default_nettype none
package pac_pkg;
  // ==========================================================
  // widths and timing
  localparam int CODE_W = 10;
  localparam int LATENCY = 5;
  localparam int CODE_MSB = CODE_W - 1;
  // format pin levels, two-bit encoding of the four input levels
  localparam logic [1:0] FMT_GND = 2'h0;
  localparam logic [1:0] FMT_THIRD = 2'h1;
  localparam logic [1:0] FMT_TWO_THIRDS = 2'h2;
  localparam logic [1:0] FMT_SUPPLY = 2'h3;
  // reset values
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
  localparam logic [2:0] SYNC_RST = 3'h0;

  typedef enum logic [1:0] {
    PAC_NORMAL, PAC_HIZ, PAC_NAP, PAC_SLEEP
  } pac_mode_t;
endpackage : pac_pkg
`default_nettype wire

// *** hw/pac_sync.sv ***
`default_nettype none
// three-stage input synchroniser; output changes once stages two and three agree
module pac_sync (
  input wire logic clk, // sample clock
  input wire logic rstn, // async reset, active low
  input wire logic din, // asynchronous level
  output logic dout // filtered level
);
  typedef struct packed {
    logic [2:0] sr;
    logic q;
  } pac_sync_state_t;
  pac_sync_state_t st, next_st;

  // shift and agree
  always_comb begin
    next_st = st;
    next_st.sr = {st.sr[1:0], din};
    if (st.sr[1] == st.sr[2]) begin
      next_st.q = st.sr[2];
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;
endmodule : pac_sync
`default_nettype wire

// *** hw/pac_top.sv ***
`default_nettype none
// digital output side of a pipelined converter
module pac_top (
  input wire logic CLK, // sample clock, 100 MHz
  input wire logic RSTN, // async reset, active low
  input wire logic [9:0] RAW_CODE, // quantiser result, offset binary
  input wire logic RAW_OVER, // quantiser out-of-range indication
  input wire logic POWER_DOWN_SELECT, // shutdown select pin
  input wire logic OUTPUT_ENABLE_N, // output enable pin, active low
  input wire logic [1:0] FORMAT_LEVEL, // four-level format pin, decoded
  output logic [9:0] SAMPLE_CODE_BITS, // result word
  output logic [9:0] SAMPLE_CODE_BITS_OE, // drive enables, high = drive
  output logic RANGE_OVERFLOW_FLAG, // overflow aligned with word
  output logic RANGE_OVERFLOW_FLAG_OE, // drive enable for flag
  output logic STABILIZER_ON, // duty-cycle stabilizer enable
  output logic CONVERTING // pipeline running
);
  // ==========================================================
  // pin synchronisers
  logic pd_s, oe_n_s;
  logic [1:0] fmt_s;
  logic [3:0] pin_in, pin_out;
  assign pin_in = {FORMAT_LEVEL, OUTPUT_ENABLE_N, POWER_DOWN_SELECT};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      pac_sync u_sync (
        .clk(CLK),
        .rstn(RSTN),
        .din(pin_in[gi]),
        .dout(pin_out[gi])
      );
    end
  endgenerate
  assign pd_s = pin_out[0];
  assign oe_n_s = pin_out[1];
  assign fmt_s = pin_out[3:2];

  // ==========================================================
  // state
  typedef struct packed {
    logic [pac_pkg::LATENCY-1:0][pac_pkg::CODE_W-1:0] code;
    logic [pac_pkg::LATENCY-1:0] over;
    pac_pkg::pac_mode_t mode;
    logic [pac_pkg::CODE_W-1:0] out_code;
    logic out_over;
    logic drive;
    logic stab;
    logic run;
  } pac_state_t;
  pac_state_t st, next_st;

  logic twos;

  // next-state logic
  always_comb begin
    next_st = st;
    // mode decode from shutdown select and output enable
    case ({pd_s, oe_n_s})
      // R3 normal drive
      2'b00: begin
        next_st.mode = pac_pkg::PAC_NORMAL;
      end
      // R4 convert, hi-z
      2'b01: begin
        next_st.mode = pac_pkg::PAC_HIZ;
      end
      // R5 nap hi-z
      2'b10: begin
        next_st.mode = pac_pkg::PAC_NAP;
      end
      // R6 sleep stop
      2'b11: begin
        next_st.mode = pac_pkg::PAC_SLEEP;
      end
      default: begin
        next_st.mode = pac_pkg::PAC_SLEEP;
      end
    endcase
    // R7 format and stabilizer
    twos = 1'b0;
    next_st.stab = 1'b0;
    case (fmt_s)
      pac_pkg::FMT_GND: begin
        twos = 1'b0;
        next_st.stab = 1'b0;
      end
      pac_pkg::FMT_THIRD: begin
        twos = 1'b0;
        next_st.stab = 1'b1;
      end
      pac_pkg::FMT_TWO_THIRDS: begin
        twos = 1'b1;
        next_st.stab = 1'b1;
      end
      pac_pkg::FMT_SUPPLY: begin
        twos = 1'b1;
        next_st.stab = 1'b0;
      end
      default: begin
        twos = 1'b0;
        next_st.stab = 1'b0;
      end
    endcase
    // pipeline runs outside nap and sleep
    next_st.run = (st.mode == pac_pkg::PAC_NORMAL) ||
                  (st.mode == pac_pkg::PAC_HIZ);
    if (st.run) begin
      // R1 sample per edge
      next_st.code[0] = RAW_CODE;
      next_st.over[0] = RAW_OVER;
      // stages one to four: a sample taken at edge n sits in stage
      // four after edge n+4, so the output stage shows it after n+5
      for (int i = 1; i < pac_pkg::LATENCY; i++) begin
        next_st.code[i] = st.code[i-1];
        next_st.over[i] = st.over[i-1];
      end
      // R2 fifth-cycle output
      // R10 msb inverted
      next_st.out_code = st.code[pac_pkg::LATENCY-1] ^
        {twos, {(pac_pkg::CODE_W-1){1'b0}}};
      // R8 aligned overflow
      next_st.out_over = st.over[pac_pkg::LATENCY-1];
    end
    // R3 drive only in normal mode
    next_st.drive = (st.mode == pac_pkg::PAC_NORMAL);
  end

  // state register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= '0;
      st.mode <= pac_pkg::PAC_SLEEP;
    end else begin
      st <= next_st;
    end
  end

  // R9 msb on bit 9
  assign SAMPLE_CODE_BITS = st.out_code;
  assign SAMPLE_CODE_BITS_OE = {pac_pkg::CODE_W{st.drive}};
  assign RANGE_OVERFLOW_FLAG = st.out_over;
  assign RANGE_OVERFLOW_FLAG_OE = st.drive;
  assign STABILIZER_ON = st.stab;
  assign CONVERTING = st.run;
endmodule : pac_top
`default_nettype wire

// *** verification/pac_cap.sv ***
`default_nettype none
module pac_cap (
  input wire logic clk, // clock
  input wire logic [9:0] code, // word
  input wire logic oe, // enable
  output logic [9:0] bus // wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] last = 10'h000;
  assign bus = oe ? code : ~last;
  always @(posedge clk) begin
    last <= bus;
  end
endmodule : pac_cap
`default_nettype wire

// *** verification/pac_sva.sv ***
`default_nettype none
module pac_sva (
  input wire logic CLK, // clock
  input wire logic RSTN, // reset
  input wire logic [9:0] RAW_CODE, // code in
  input wire logic RAW_OVER, // over in
  input wire logic POWER_DOWN_SELECT, // pin
  input wire logic OUTPUT_ENABLE_N, // pin
  input wire logic [1:0] FORMAT_LEVEL, // pin
  input wire logic [9:0] SAMPLE_CODE_BITS, // word
  input wire logic [9:0] SAMPLE_CODE_BITS_OE, // enables
  input wire logic RANGE_OVERFLOW_FLAG, // flag
  input wire logic RANGE_OVERFLOW_FLAG_OE, // enable
  input wire logic STABILIZER_ON, // stabilizer
  input wire logic CONVERTING // running
);
  // ==========
  // settled pins against mode, drive and pipeline
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire logic [2:0] pin = {RSTN, POWER_DOWN_SELECT, OUTPUT_ENABLE_N};
  wire logic oe = RANGE_OVERFLOW_FLAG_OE;
  wire logic run = CONVERTING;
  chk_drive_on: assert property ((pin == 3'h4)[*8] |-> run && oe)
    else $error("bad drive mode");
  chk_hiz_run: assert property ((pin == 3'h5)[*8] |-> run && !oe)
    else $error("bad hiz mode");
  chk_nap_off: assert property ((pin == 3'h6)[*8] |-> !run && !oe)
    else $error("bad nap mode");
  chk_sleep_off: assert property ((pin == 3'h7)[*8] |-> !run && !oe)
    else $error("bad sleep mode");
  chk_oe_same: assert property (SAMPLE_CODE_BITS_OE == {10{oe}})
    else $error("enables differ");
  chk_fmt_stab: assert property (($stable(FORMAT_LEVEL) && RSTN)[*8]
    |-> STABILIZER_ON == (FORMAT_LEVEL inside {2'h1, 2'h2}))
    else $error("bad stabilizer");
  chk_word_lat: assert property (($stable(FORMAT_LEVEL) && run)[*8]
    |-> SAMPLE_CODE_BITS == {$past(RAW_CODE[9], 6) ^ FORMAT_LEVEL[1],
    $past(RAW_CODE[8:0], 6)})
    else $error("bad word");
  chk_ovf_lat: assert property (run[*7] |-> RANGE_OVERFLOW_FLAG ==
    $past(RAW_OVER, 6))
    else $error("bad overflow");
endmodule : pac_sva
bind pac_top pac_sva pac_sva_inst (.*);
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
`define CHK(a, b) check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, pds = 0, oen = 0, over = 0;
  logic [9:0] raw = 10'h000;
  logic [1:0] fmt = 2'h0;
  logic [9:0] code, code_oe, bus;
  logic ovf, ovf_oe, stab, run;
  int n_errors = 0, check_count = 0;
  // ==========
  // device and capture side
  pac_top pac_top_inst (.CLK(clk), .RSTN(rstn), .RAW_CODE(raw),
    .RAW_OVER(over), .POWER_DOWN_SELECT(pds), .OUTPUT_ENABLE_N(oen),
    .FORMAT_LEVEL(fmt), .SAMPLE_CODE_BITS(code),
    .SAMPLE_CODE_BITS_OE(code_oe), .RANGE_OVERFLOW_FLAG(ovf),
    .RANGE_OVERFLOW_FLAG_OE(ovf_oe), .STABILIZER_ON(stab),
    .CONVERTING(run));
  pac_cap pac_cap_inst (.clk(clk), .code(code), .oe(code_oe[0]), .bus(bus));
  task finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // bounded wait for the running flag
  task wait_run(input logic v);
    for (int k = 0; k < 20 && run !== v; k++) @(negedge clk);
    if (run !== v) begin
      n_errors++;
      finish_test();
    end
  endtask : wait_run
  // back-to-back samples through the pipeline in one format
  task t_stream(input logic [1:0] f);
    logic [9:0] e;
    {pds, oen} = 2'h0;
    fmt = f;
    wait_run(1'b1);
    repeat (8) @(negedge clk);
    `CHK(stab, logic'(f inside {2'h1, 2'h2}))
    `CHK(code_oe, 10'h3ff)
    for (int i = 0; i < 16; i++) begin
      raw = 10'(i * 71);
      over = i[0];
      @(negedge clk);
      e = 10'((i - 5) * 71);
      if (i >= 5) begin
        `CHK(bus, {e[9] ^ f[1], e[8:0]})
        `CHK(ovf, ~i[0])
      end
    end
  endtask : t_stream
  // hi-z, nap and sleep in turn
  task t_modes();
    for (int m = 1; m < 4; m++) begin
      {pds, oen} = 2'(m);
      wait_run(m == 1);
      repeat (8) @(negedge clk);
      `CHK({run, ovf_oe, code_oe}, {m == 1, 11'h000})
    end
  endtask : t_modes
  // clock
  initial begin
    forever #5 clk = ~clk;
  end
  // main sequence, wake from sleep at the end
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1;
    for (int f = 0; f < 4; f++) t_stream(2'(f));
    t_modes();
    t_stream(2'h1);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
